/* design/pcr_pkg.sv */
// package for the port configuration and pin remap block
// assumes one 8-bit special-function register bus on the system clock
package pcr_pkg;

   // -------------------------------------------------------------
   // pin numbering: port0 0..7, port1 8..15, port3 16..17
   // -------------------------------------------------------------
   localparam int PCR_NPINS = 18;
   localparam int PCR_P0_BASE = 0;
   localparam int PCR_P1_BASE = 8;
   localparam int PCR_P3_BASE = 16;
   localparam int PCR_P3_WIDTH = 2;
   localparam int PCR_PORT_WIDTH = 8;
   localparam int PCR_PIN_P0_0 = 0;
   localparam int PCR_PIN_P1_0 = 8;
   localparam int PCR_PIN_P1_1 = 9;
   localparam int PCR_PIN_P1_2 = 10;
   localparam int PCR_PIN_P1_3 = 11;
   localparam int PCR_PIN_P1_4 = 12;
   localparam int PCR_PIN_P1_5 = 13;
   localparam int PCR_PIN_P1_6 = 14;
   localparam int PCR_PIN_P1_7 = 15;

   // -------------------------------------------------------------
   // register addresses
   // -------------------------------------------------------------
   localparam logic [7:0] PCR_ADDR_REMAP = 8'hcf;
   localparam logic [7:0] PCR_ADDR_P0_FIRST = 8'h84;
   localparam logic [7:0] PCR_ADDR_P0_SECOND = 8'h85;
   localparam logic [7:0] PCR_ADDR_P1_FIRST = 8'h91;
   localparam logic [7:0] PCR_ADDR_P1_SECOND = 8'h92;
   localparam logic [7:0] PCR_ADDR_P3_FIRST = 8'hb1;
   localparam logic [7:0] PCR_ADDR_P3_SECOND = 8'hb2;

   // -------------------------------------------------------------
   // remap fields and reset values
   // -------------------------------------------------------------
   localparam int PCR_REMAP_SPI_BIT = 1;
   localparam int PCR_REMAP_UART_BIT = 2;
   localparam logic [17:0] PCR_FIRST_RST = 18'h3_ffff;
   localparam logic [17:0] PCR_SECOND_RST = 18'h0_0000;
   localparam logic [7:0] PCR_READ_NONE = 8'h00;

   // -------------------------------------------------------------
   // output mode encodings {first, second}
   // -------------------------------------------------------------
   localparam logic [1:0] PCR_MODE_QUASI = 2'h0;
   localparam logic [1:0] PCR_MODE_PUSH = 2'h1;
   localparam logic [1:0] PCR_MODE_INPUT = 2'h2;
   localparam logic [1:0] PCR_MODE_OPEN = 2'h3;

   typedef enum logic [2:0] {
      PCR_KIND_FULL = 3'b001,
      PCR_KIND_ODONLY = 3'b010,
      PCR_KIND_INONLY = 3'b100
   } pcr_pin_kind_t;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic wrEn;
      logic rdEn;
   } pcr_sfr_req_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic pu;
   } pcr_drive_t;

   typedef struct packed {
      logic uartTxd;
      logic sdaOut;
      logic sclOut;
      logic spiClkOut;
      logic mosiOut;
      logic misoOut;
   } pcr_periph_out_t;

   typedef struct packed {
      logic uartRxd;
      logic sdaIn;
      logic sclIn;
      logic spiClkIn;
      logic mosiIn;
      logic misoIn;
      logic ssIn;
   } pcr_periph_in_t;

   localparam pcr_periph_in_t PCR_PERIPH_IDLE = 7'h7f;

   typedef struct packed {
      logic [17:0] modeFirst;
      logic [17:0] modeSecond;
      logic spiAlt;
      logic uartAlt;
      logic [17:0] syncA;
      logic [17:0] syncB;
      logic [17:0] pinOut;
      logic [17:0] pinOe;
      logic [17:0] pinPu;
      logic [7:0] rdData;
      pcr_periph_in_t toPeriph;
   } pcr_state_t;

endpackage

/* design/pcr_pin_cell.sv */
// one pin's output driver decode from its two mode bits
// assumes the caller registers the result before it reaches a pad
`timescale 1ns/1ps
`default_nettype none
module pcr_pin_cell
   import pcr_pkg::*;
#(
   parameter pcr_pin_kind_t KIND = PCR_KIND_FULL
) (
   input wire logic [1:0] mode,
   input wire logic latch,
   output pcr_drive_t drive
);
   logic [1:0] effMode;

   always_comb begin
      effMode = mode;
      case (KIND)
         PCR_KIND_INONLY: begin
            effMode = PCR_MODE_INPUT;
         end
         PCR_KIND_ODONLY: begin
            if (!mode[1]) begin
               effMode = PCR_MODE_INPUT;
            end
         end
         default: begin
            effMode = mode;
         end
      endcase
      drive = '0;
      case (effMode)
         PCR_MODE_QUASI: begin
            drive.oe = !latch;
            drive.pu = latch;
         end
         PCR_MODE_PUSH: begin
            drive.oe = 1'b1;
            drive.out = latch;
         end
         PCR_MODE_OPEN: begin
            drive.oe = !latch;
         end
         default: begin
            drive = '0;
         end
      endcase
   end
endmodule
`default_nettype wire

/* design/pcr_port_remap.sv */
// port mode registers, pin remap control and pin drive registers
// assumes an 8-bit register bus and pin levels from another domain
//
// Functional notes
// - all pins input-only after power-up
// - port1_bit5 always input, mode bits ignored
// - port1_bit2/bit3 only input-only or open-drain
// - two mode bits per pin select output type
// - peripherals reach pins through remap multiplexers
// - UART and SPI maps selectable independently, I2C fixed on port1_bit2/bit3
// - UART bit clear primary map, set disconnects UART
// - reset clears both remap bits: UART on primary map, SPI disconnected
// - SPI bit clear disconnects, set routes alternative
// - remap bit 2 selects UART map
`timescale 1ns/1ps
`default_nettype none
module pcr_port_remap
   import pcr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire pcr_sfr_req_t sfrReq,
   output logic [7:0] sfrRdData,
   input wire logic [17:0] portLatch,
   input wire logic [17:0] pinIn,
   output logic [17:0] pinOut,
   output logic [17:0] pinOe,
   output logic [17:0] pinPu,
   input wire pcr_periph_out_t fromPeriph,
   output pcr_periph_in_t toPeriph
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   pcr_state_t st_q;
   pcr_state_t st_d;
   logic [17:0] effLatch;
   pcr_drive_t drv [PCR_NPINS];

   // -------------------------------------------------------------
   // peripheral signals merged into the port latches
   // -------------------------------------------------------------
   always_comb begin
      effLatch = portLatch;
      if (!st_q.uartAlt) begin
         effLatch[PCR_PIN_P1_0] = portLatch[PCR_PIN_P1_0]
            & fromPeriph.uartTxd;
      end
      effLatch[PCR_PIN_P1_3] = portLatch[PCR_PIN_P1_3]
         & fromPeriph.sdaOut;
      effLatch[PCR_PIN_P1_2] = portLatch[PCR_PIN_P1_2]
         & fromPeriph.sclOut;
      if (st_q.spiAlt) begin
         effLatch[PCR_PIN_P0_0] = portLatch[PCR_PIN_P0_0]
            & fromPeriph.spiClkOut;
         effLatch[PCR_PIN_P1_7] = portLatch[PCR_PIN_P1_7]
            & fromPeriph.mosiOut;
         effLatch[PCR_PIN_P1_6] = portLatch[PCR_PIN_P1_6]
            & fromPeriph.misoOut;
      end
   end

   // -------------------------------------------------------------
   // per-pin driver decode
   // -------------------------------------------------------------
   for (genvar i = 0; i < PCR_NPINS; i++) begin : gPin
      localparam pcr_pin_kind_t K = (i == PCR_PIN_P1_5) ? PCR_KIND_INONLY :
         ((i == PCR_PIN_P1_2) || (i == PCR_PIN_P1_3)) ? PCR_KIND_ODONLY :
         PCR_KIND_FULL;
      pcr_pin_cell #(.KIND(K)) uCell (
         .mode({st_q.modeFirst[i], st_q.modeSecond[i]}),
         .latch(effLatch[i]),
         .drive(drv[i])
      );
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.syncA = pinIn;
      st_d.syncB = st_q.syncA;
      for (int i = 0; i < PCR_NPINS; i++) begin
         st_d.pinOut[i] = drv[i].out;
         st_d.pinOe[i] = drv[i].oe;
         st_d.pinPu[i] = drv[i].pu;
      end
      if (sfrReq.wrEn) begin
         case (sfrReq.addr)
            PCR_ADDR_REMAP: begin
               st_d.spiAlt = sfrReq.wrData[PCR_REMAP_SPI_BIT];
               st_d.uartAlt = sfrReq.wrData[PCR_REMAP_UART_BIT];
            end
            PCR_ADDR_P0_FIRST: begin
               st_d.modeFirst[PCR_P0_BASE +: PCR_PORT_WIDTH] =
                  sfrReq.wrData;
            end
            PCR_ADDR_P0_SECOND: begin
               st_d.modeSecond[PCR_P0_BASE +: PCR_PORT_WIDTH] =
                  sfrReq.wrData;
            end
            PCR_ADDR_P1_FIRST: begin
               st_d.modeFirst[PCR_P1_BASE +: PCR_PORT_WIDTH] =
                  sfrReq.wrData;
            end
            PCR_ADDR_P1_SECOND: begin
               st_d.modeSecond[PCR_P1_BASE +: PCR_PORT_WIDTH] =
                  sfrReq.wrData;
            end
            PCR_ADDR_P3_FIRST: begin
               st_d.modeFirst[PCR_P3_BASE +: PCR_P3_WIDTH] =
                  sfrReq.wrData[PCR_P3_WIDTH-1:0];
            end
            PCR_ADDR_P3_SECOND: begin
               st_d.modeSecond[PCR_P3_BASE +: PCR_P3_WIDTH] =
                  sfrReq.wrData[PCR_P3_WIDTH-1:0];
            end
            default: begin
               st_d.spiAlt = st_q.spiAlt;
            end
         endcase
      end
      if (sfrReq.rdEn) begin
         case (sfrReq.addr)
            PCR_ADDR_REMAP: begin
               st_d.rdData = PCR_READ_NONE;
               st_d.rdData[PCR_REMAP_SPI_BIT] = st_q.spiAlt;
               st_d.rdData[PCR_REMAP_UART_BIT] = st_q.uartAlt;
            end
            PCR_ADDR_P0_FIRST: begin
               st_d.rdData = st_q.modeFirst[PCR_P0_BASE +: PCR_PORT_WIDTH];
            end
            PCR_ADDR_P0_SECOND: begin
               st_d.rdData = st_q.modeSecond[PCR_P0_BASE +: PCR_PORT_WIDTH];
            end
            PCR_ADDR_P1_FIRST: begin
               st_d.rdData = st_q.modeFirst[PCR_P1_BASE +: PCR_PORT_WIDTH];
            end
            PCR_ADDR_P1_SECOND: begin
               st_d.rdData = st_q.modeSecond[PCR_P1_BASE +: PCR_PORT_WIDTH];
            end
            PCR_ADDR_P3_FIRST: begin
               st_d.rdData = PCR_READ_NONE;
               st_d.rdData[PCR_P3_WIDTH-1:0] =
                  st_q.modeFirst[PCR_P3_BASE +: PCR_P3_WIDTH];
            end
            PCR_ADDR_P3_SECOND: begin
               st_d.rdData = PCR_READ_NONE;
               st_d.rdData[PCR_P3_WIDTH-1:0] =
                  st_q.modeSecond[PCR_P3_BASE +: PCR_P3_WIDTH];
            end
            default: begin
               st_d.rdData = PCR_READ_NONE;
            end
         endcase
      end
      // inputs handed to peripherals; unrouted ones sit idle high
      st_d.toPeriph = PCR_PERIPH_IDLE;
      st_d.toPeriph.sdaIn = st_q.syncB[PCR_PIN_P1_3];
      st_d.toPeriph.sclIn = st_q.syncB[PCR_PIN_P1_2];
      if (!st_q.uartAlt) begin
         st_d.toPeriph.uartRxd = st_q.syncB[PCR_PIN_P1_1];
      end
      if (st_q.spiAlt) begin
         st_d.toPeriph.spiClkIn = st_q.syncB[PCR_PIN_P0_0];
         st_d.toPeriph.mosiIn = st_q.syncB[PCR_PIN_P1_7];
         st_d.toPeriph.misoIn = st_q.syncB[PCR_PIN_P1_6];
         st_d.toPeriph.ssIn = st_q.syncB[PCR_PIN_P1_4];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.modeFirst <= PCR_FIRST_RST;
         st_q.modeSecond <= PCR_SECOND_RST;
         st_q.toPeriph <= PCR_PERIPH_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign sfrRdData = st_q.rdData;
   assign pinOut = st_q.pinOut;
   assign pinOe = st_q.pinOe;
   assign pinPu = st_q.pinPu;
   assign toPeriph = st_q.toPeriph;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_reset_input_only: assert property (@(posedge ref_clk) disable iff (!rstn)
      (st_q.modeFirst == PCR_FIRST_RST && st_q.modeSecond == PCR_SECOND_RST)
      |=> (pinOe == '0 && pinPu == '0))
      else $error("pins drive while all modes are input-only");
   a_bit5_never_drives: assert property (@(posedge ref_clk) disable iff (!rstn)
      !pinOe[PCR_PIN_P1_5] && !pinPu[PCR_PIN_P1_5])
      else $error("port1_bit5 is driven");
   a_i2c_pins_open: assert property (@(posedge ref_clk) disable iff (!rstn)
      !pinPu[PCR_PIN_P1_2] && !pinPu[PCR_PIN_P1_3]
      && !(pinOe[PCR_PIN_P1_2] && pinOut[PCR_PIN_P1_2]))
      else $error("i2c pin driven high");
   a_push_pull_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!st_q.modeFirst[PCR_PIN_P1_4] && st_q.modeSecond[PCR_PIN_P1_4])
      |=> pinOe[PCR_PIN_P1_4]
      && pinOut[PCR_PIN_P1_4] == $past(effLatch[PCR_PIN_P1_4]))
      else $error("push-pull pin not driven");
   a_uart_tx_route: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!st_q.uartAlt && !st_q.modeFirst[PCR_PIN_P1_0]
      && st_q.modeSecond[PCR_PIN_P1_0]) |=> pinOut[PCR_PIN_P1_0] ==
      $past(portLatch[PCR_PIN_P1_0] & fromPeriph.uartTxd))
      else $error("uart transmit not on port1_bit0");
   a_remap_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      (sfrReq.wrEn && sfrReq.addr == PCR_ADDR_REMAP)
      |=> st_q.spiAlt == $past(sfrReq.wrData[PCR_REMAP_SPI_BIT])
      && st_q.uartAlt == $past(sfrReq.wrData[PCR_REMAP_UART_BIT]))
      else $error("remap write not taken");
   a_spi_disconnect: assert property (@(posedge ref_clk) disable iff (!rstn)
      !st_q.spiAlt |=> toPeriph.spiClkIn && toPeriph.ssIn
      && toPeriph.misoIn && toPeriph.mosiIn)
      else $error("spi input routed while unmapped");
   a_spi_route: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q.spiAlt |=> toPeriph.ssIn == $past(st_q.syncB[PCR_PIN_P1_4])
      ##1 1'b1)
      else $error("spi select not taken from port1_bit4");
   a_uart_alt_rx: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q.uartAlt |=> toPeriph.uartRxd)
      else $error("uart receive routed under alternative map");
   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
      (sfrReq.rdEn && sfrReq.addr == PCR_ADDR_REMAP)
      |=> sfrRdData[0] == 1'b0 && sfrRdData[7:3] == 5'h00)
      else $error("reserved remap bits read non-zero");
endmodule
`default_nettype wire

/* verif/pcr_periph_model.sv */
// far-side model of the UART, I2C and SPI peripheral outputs
// assumes the bench picks the levels; idle is all ones after reset
`timescale 1ns/1ps
`default_nettype none
module pcr_periph_model
   import pcr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [5:0] level,
   output pcr_periph_out_t fromPeriph
);
   // registered like a real peripheral output, idle high on reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fromPeriph <= '1;
      end else begin
         fromPeriph <= pcr_periph_out_t'(level);
      end
   end
endmodule
`default_nettype wire

/* verif/pcr_port_remap_tb_top.sv */
// self-checking bench for the port configuration and pin remap block
// assumes the peripheral model sits on the far side of the remap muxes
`timescale 1ns/1ps
`default_nettype none
module pcr_port_remap_tb_top
   import pcr_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   pcr_sfr_req_t req = '0;
   logic [7:0] rdData;
   logic [17:0] portLatch = '0;
   logic [17:0] pinIn = '0;
   logic [17:0] pinOut, pinOe, pinPu;
   logic [5:0] level = '1;
   pcr_periph_out_t fromPeriph;
   pcr_periph_in_t toPeriph;
   int numErrors = 0;
   int comparisons = 0;

   pcr_port_remap u_pcr_port_remap (.ref_clk(ref_clk), .rstn(rstn),
      .sfrReq(req), .sfrRdData(rdData), .portLatch(portLatch),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPu(pinPu),
      .fromPeriph(fromPeriph), .toPeriph(toPeriph));
   pcr_periph_model u_pcr_periph_model (.ref_clk(ref_clk), .rstn(rstn),
      .level(level), .fromPeriph(fromPeriph));

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic chk(input string nm, input logic [17:0] e, got);
      comparisons++;
      if (got !== e) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", nm, e, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
      @(negedge ref_clk);
      req.wrEn = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      req = '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
      @(negedge ref_clk);
      req.rdEn = 1'b0;
      @(negedge ref_clk);
      chk($sformatf("read %h", a), {10'h000, e}, {10'h000, rdData});
   endtask

   task automatic set_modes(input logic [1:0] m);
      wr(PCR_ADDR_P0_FIRST, {8{m[1]}});
      wr(PCR_ADDR_P0_SECOND, {8{m[0]}});
      wr(PCR_ADDR_P1_FIRST, {8{m[1]}});
      wr(PCR_ADDR_P1_SECOND, {8{m[0]}});
      wr(PCR_ADDR_P3_FIRST, {8{m[1]}});
      wr(PCR_ADDR_P3_SECOND, {8{m[0]}});
   endtask

   task automatic printVerdict();
      $display("comparisons %0d mismatches %0d", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_reset();
      // reset only lands on the first clock edge, so look after it
      @(negedge ref_clk);
      chk("periph in during reset", 18'h0007f, {11'h0, toPeriph});
      repeat (15) @(negedge ref_clk);
      rstn = 1'b1;
      chk("oe after reset", 18'h0, pinOe);
      chk("pu after reset", 18'h0, pinPu);
      rd(PCR_ADDR_P0_FIRST, 8'hff);
      rd(PCR_ADDR_P1_SECOND, 8'h00);
      rd(PCR_ADDR_P3_FIRST, 8'h03);
      rd(PCR_ADDR_REMAP, 8'h00);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_modes();
      logic [1:0] m;
      logic lat;
      logic [7:0] o0, o1, p0;
      for (int i = 0; i < 8; i++) begin
         m = i[1:0];
         lat = i[2];
         set_modes(m);
         portLatch = {18{lat}};
         repeat (2) @(negedge ref_clk);
         o0 = {8{m == PCR_MODE_PUSH || (m != PCR_MODE_INPUT && !lat)}};
         o1 = (o0 & 8'hd3) | ((m == PCR_MODE_OPEN && !lat) ? 8'h0c : 8'h00);
         p0 = {8{m == PCR_MODE_QUASI && lat}};
         chk("mode oe", {o0[1:0], o1, o0}, pinOe);
         chk("mode pu", {p0[1:0], p0 & 8'hd3, p0}, pinPu);
         chk("mode out", {18{m == PCR_MODE_PUSH && lat}} & {o0[1:0], o1, o0},
            pinOut & pinOe);
         rd(PCR_ADDR_P3_SECOND, {6'h00, {2{m[0]}}});
      end
      $display("test modes done");
   endtask

   task automatic t_remap();
      logic [7:0] rv[5] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'hf9};
      logic [6:0] ti[5] = '{7'h2f, 7'h2a, 7'h6f, 7'h6a, 7'h2f};
      logic [3:0] po[5] = '{4'hd, 4'h8, 4'hf, 4'ha, 4'hd};
      set_modes(PCR_MODE_PUSH);
      portLatch = '1;
      // distinct levels on neighbouring routed pins expose swapped routes
      pinIn = 18'h0_4801;
      level = 6'b011010;
      for (int i = 0; i < 5; i++) begin
         wr(PCR_ADDR_REMAP, rv[i]);
         repeat (4) @(negedge ref_clk);
         chk("remap in", {11'h0, ti[i]}, {11'h0, toPeriph});
         chk("remap out", {14'h0, po[i]},
            {14'h0, pinOut[15], pinOut[14], pinOut[8], pinOut[0]});
         rd(PCR_ADDR_REMAP, rv[i] & 8'h06);
      end
      $display("test remap done");
   endtask

   task automatic t_i2c();
      set_modes(PCR_MODE_OPEN);
      wr(PCR_ADDR_REMAP, 8'h06);
      portLatch = '1;
      level = 6'b101111;
      repeat (3) @(negedge ref_clk);
      chk("i2c oe", 18'h2, {16'h0, pinOe[11:10]});
      chk("i2c out", 18'h0, {17'h0, pinOut[11]});
      level = '1;
      repeat (3) @(negedge ref_clk);
      chk("i2c release", 18'h0, {16'h0, pinOe[11:10]});
      $display("test i2c done");
   endtask

   task automatic t_rearm();
      set_modes(PCR_MODE_PUSH);
      wr(PCR_ADDR_REMAP, 8'h06);
      rstn = 1'b0;
      @(negedge ref_clk);
      chk("oe in reset", 18'h0, pinOe);
      rstn = 1'b1;
      @(negedge ref_clk);
      rd(PCR_ADDR_REMAP, 8'h00);
      rd(PCR_ADDR_P1_FIRST, 8'hff);
      $display("test rearm done");
   endtask

   initial begin
      t_reset();
      t_modes();
      t_remap();
      t_i2c();
      t_rearm();
      printVerdict();
   end

   initial begin
      #2_000_000;
      numErrors++;
      printVerdict();
   end
endmodule
`default_nettype wire
